// *** logic/gsr_pkg.sv ***
package gsr_pkg;

   // smbus slave address of a smart battery, and bits per byte of the protocol
   localparam logic [6:0] GSR_SLAVE_ADDR = 7'h0b;
   localparam logic [3:0] GSR_BITS_BYTE  = 4'h8;

   // function codes served by this bank
   localparam logic [7:0] GSR_FC_STATUS  = 8'h16;
   localparam logic [7:0] GSR_FC_CYCLE   = 8'h17;
   localparam logic [7:0] GSR_FC_DCAP    = 8'h18;
   localparam logic [7:0] GSR_FC_DVOLT   = 8'h19;
   localparam logic [7:0] GSR_FC_SPEC    = 8'h1a;
   localparam logic [7:0] GSR_FC_DATE    = 8'h1b;
   localparam logic [7:0] GSR_FC_SERIAL  = 8'h1c;
   localparam logic [7:0] GSR_FC_MAKER   = 8'h20;
   localparam logic [7:0] GSR_FC_MODEL   = 8'h21;
   localparam logic [7:0] GSR_FC_CHEM    = 8'h22;
   localparam logic [7:0] GSR_FC_MDATA   = 8'h23;
   localparam logic [7:0] GSR_FC_PACK    = 8'h2f;
   // defined codes answered elsewhere in the gauge: treated as unsupported
   localparam logic [7:0] GSR_FC_STD_LAST = 8'h15;
   localparam logic [7:0] GSR_FC_CELL_LO  = 8'h3c;
   localparam logic [7:0] GSR_FC_CELL_HI  = 8'h3f;

   // error code encodings of the status word
   localparam logic [2:0] GSR_ERR_OK    = 3'h0;
   localparam logic [2:0] GSR_ERR_BUSY  = 3'h1;
   localparam logic [2:0] GSR_ERR_RSVD  = 3'h2;
   localparam logic [2:0] GSR_ERR_UNSUP = 3'h3;
   localparam logic [2:0] GSR_ERR_DENY  = 3'h4;
   localparam logic [2:0] GSR_ERR_OVF   = 3'h5;
   localparam logic [2:0] GSR_ERR_SIZE  = 3'h6;
   localparam logic [2:0] GSR_ERR_UNK   = 3'h7;

   // misc values
   localparam logic [15:0] GSR_CYC_MAX      = 16'hffff;
   localparam logic [6:0]  GSR_RECOVER_PCT  = 7'h14; // 20 percent
   localparam logic [3:0]  GSR_SCALE_ZERO   = 4'h0;
   localparam logic [3:0]  GSR_WORD_BYTES   = 4'h2;
   localparam logic [3:0]  GSR_MAKER_BYTES  = 4'hc;
   localparam logic [3:0]  GSR_MODEL_BYTES  = 4'h8;
   localparam logic [3:0]  GSR_SHORT_BYTES  = 4'h6;
   localparam logic [3:0]  GSR_IDX_MAX      = 4'hf;

   // events and levels from the gauge core, same clock domain
   typedef struct packed {
      logic        cal_done;     // pulse: factory calibration complete
      logic        cal_lost;     // pulse: calibration data lost/corrupt
      logic        charging;     // level: charge current detected
      logic        term_reached; // pulse: charge termination point
      logic        charge_ok;    // pulse: battery may accept charge again
      logic        depleted;     // pulse: further discharge is harmful
      logic [6:0]  relative_charge_percent;
      logic        cyc_inc;      // pulse: one more cycle of charge removed
      logic        cyc_load;     // pulse: load count restored from eeprom
      logic [15:0] cyc_load_val;
      logic        busy;         // level: core cannot serve a code now
      logic        ovf_evt;      // pulse: arithmetic over/underflow
      logic        unk_evt;      // pulse: unclassified error
      logic        lithium;      // level: pack chemistry is lithium
      logic        cell_ov;      // level: a cell is above high limit
      logic        cell_uv;      // level: a cell is below low limit
      logic        capacity_mode; // mode bit of gauge_mode_word
   } gsr_evt_t;

   // identity and capacity data loaded from configuration memory
   typedef struct packed {
      logic [15:0] cap_mah;
      logic [15:0] cap_10mwh;
      logic [15:0] volt_mv;
      logic [3:0]  spec_major;
      logic [3:0]  spec_minor;
      logic [6:0]  date_year;   // year minus 1980
      logic [3:0]  date_month;
      logic [4:0]  date_day;
      logic [15:0] serial;
      logic [95:0] maker_blk;   // byte 0 is the length
      logic [63:0] model_blk;
      logic [47:0] chem_blk;
      logic [47:0] mdata_blk;
      logic [7:0]  pack_cfg;
   } gsr_id_t;

   typedef enum logic [3:0] {
      GSR_IDLE    = 4'b0000,
      GSR_ADDR    = 4'b0001,
      GSR_ACK_A   = 4'b0010,
      GSR_CMD     = 4'b0011,
      GSR_ACK_C   = 4'b0100,
      GSR_WDATA   = 4'b0101,
      GSR_ACK_W   = 4'b0110,
      GSR_TX      = 4'b0111,
      GSR_TX_ACK  = 4'b1000,
      GSR_TX_LD   = 4'b1001,
      GSR_IGNORE  = 4'b1010
   } gsr_phase_t;

endpackage

// *** logic/gsr_status_info_regs.sv ***
`timescale 1ns/1ns
// Functional notes
// - calibrated flag: set on calibration done, cleared on data loss.
// - not-charging flag: set with no charge, cleared when charging.
// - charge-done flag: set at termination, cleared when charge allowed.
// - depleted flag: set on harmful discharge, cleared at charge >= 20%.
// - status word bits 2:0 hold the 3-bit error code.
// - OK after clean processing, busy when a code cannot be served.
// - reserved error for reserved or unsupported maker codes.
// - unsupported error for defined but unimplemented codes.
// - access-denied on a write to a read-only code.
// - overflow code on over/underflow, unknown code otherwise.
// - bad-size when a write carries a block of wrong size.
// - code 0x17 returns cycle count; each increment is saved, a load is not.
// - cycle count steps by one, saturates at 65,535, never wraps.
// - code 0x18 returns design capacity in mAh or 10mWh by mode.
// - code 0x19 returns nominal voltage in millivolts.
// - code 0x1a returns revision and version; scaling fields zero.
// - code 0x1b returns packed date: day, month, year minus 1980.
// - code 0x1c returns the serial number.
// - code 0x20: maker name block, length plus up to 11 chars.
// - code 0x21: model name block, length plus up to 7 chars.
// - code 0x22: chemistry block; not used for gauging.
// - code 0x23: maker data block, length plus up to 5 bytes.
// - code 0x2f: protection status low byte, pack config high byte.
// - protection byte: charge-fet, discharge-fet pins, cell ov, uv.
// - cell ov and uv bits are live, lithium packs only.
module gsr_status_info_regs
(
   input  wire logic            ref_clk,
   input  wire logic            nrst,
   input  wire logic            scl_i,
   input  wire logic            sda_i,
   output logic                 sda_o,
   output logic                 sda_oe,
   input  wire logic            charge_fet_control_pin,
   input  wire logic            discharge_fet_control_pin,
   input  wire gsr_pkg::gsr_evt_t evt,
   input  wire gsr_pkg::gsr_id_t  id,
   output logic [15:0]          gauge_status_word,
   output logic [15:0]          wear_cycle_count,
   output logic                 cycle_save_stb
);
   import gsr_pkg::*;

   typedef struct packed {
      gsr_phase_t   ph;
      logic [3:0]   bitcnt;
      logic [7:0]   shreg;
      logic         rw;
      logic [7:0]   cmd;
      logic [3:0]   idx;
      logic [3:0]   nbytes;
      logic         ovf_rd;
      logic [127:0] rdbuf;
      logic [4:0]   wcnt;
      logic [7:0]   wlen;
      logic [2:0]   err;
      logic         calibrated_flag;
      logic         not_charging_flag;
      logic         charge_done_flag;
      logic         depleted_flag;
      logic [15:0]  cyc;
      logic         cyc_save;
      logic         sda_oe;
      logic         sda_o;
      logic [2:0]   scl_s;
      logic [2:0]   sda_s;
      logic [1:0]   cfc_s;
      logic [1:0]   dfc_s;
      logic [7:0]   prot;
   } gsr_state_t;

   gsr_state_t st_r;
   gsr_state_t st_nxt;
   logic       rst_s1_r;
   logic       rst_n_r;

   logic       scl_rise;
   logic       scl_fall;
   logic       bus_start;
   logic       bus_stop;
   logic [7:0] tx_byte;
   logic [15:0] status_w;

   // reset is released through two flops so every flop leaves it together
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // classify a function code; only the codes of this bank are accepted
   function automatic logic [2:0] classify(input logic [7:0] fc);
      logic [2:0] e;
      e = GSR_ERR_RSVD;
      if ((fc <= GSR_FC_STD_LAST) ||
          (fc >= GSR_FC_CELL_LO && fc <= GSR_FC_CELL_HI))
         e = GSR_ERR_UNSUP;
      if ((fc >= GSR_FC_STATUS && fc <= GSR_FC_SERIAL) ||
          (fc >= GSR_FC_MAKER && fc <= GSR_FC_MDATA) ||
          (fc == GSR_FC_PACK))
         e = GSR_ERR_OK;
      return e;
   endfunction

   // size in bytes that a write to the code would have to carry
   function automatic logic [3:0] code_size(input logic [7:0] fc);
      logic [3:0] n;
      unique case (fc)
         GSR_FC_MAKER: n = GSR_MAKER_BYTES;
         GSR_FC_MODEL: n = GSR_MODEL_BYTES;
         GSR_FC_CHEM,
         GSR_FC_MDATA: n = GSR_SHORT_BYTES;
         default:      n = GSR_WORD_BYTES;
      endcase
      return n;
   endfunction

   // bytes after the last valid one read as all ones
   function automatic logic [127:0] fill(input logic [95:0] d,
                                         input logic [3:0] n);
      logic [127:0] b;
      b = {16{8'hff}};
      for (int i = 0; i < 12; i++)
         if (4'(i) < n)
            b[i*8 +: 8] = d[i*8 +: 8];
      return b;
   endfunction

   // edges are taken from the second and third sync flops only
   assign scl_rise  = st_r.scl_s[1] & ~st_r.scl_s[2];
   assign scl_fall  = ~st_r.scl_s[1] & st_r.scl_s[2];
   assign bus_start = st_r.scl_s[1] & st_r.sda_s[2] & ~st_r.sda_s[1];
   assign bus_stop  = st_r.scl_s[1] & ~st_r.sda_s[2] & st_r.sda_s[1];
   assign tx_byte   = st_r.rdbuf[st_r.idx*8 +: 8];

   // status word: alarm byte is outside this bank and reads zero
   assign status_w = {8'h00, st_r.calibrated_flag, st_r.not_charging_flag,
                      st_r.charge_done_flag, st_r.depleted_flag, 1'b0,
                      st_r.err};

   always_comb
   begin
      logic [95:0] rd;
      logic [3:0]  rn;
      logic [2:0]  cls;
      rd = '0;
      rn = GSR_WORD_BYTES;
      cls = classify(st_r.cmd);
      st_nxt = st_r;
      st_nxt.cyc_save = 1'b0;

      // pin synchronisers; the first stage feeds only the second
      st_nxt.scl_s = {st_r.scl_s[1:0], scl_i};
      st_nxt.sda_s = {st_r.sda_s[1:0], sda_i};
      st_nxt.cfc_s = {st_r.cfc_s[0], charge_fet_control_pin};
      st_nxt.dfc_s = {st_r.dfc_s[0], discharge_fet_control_pin};

      // protection byte is rebuilt every cycle, nothing latches
      st_nxt.prot = {4'h0, st_r.cfc_s[1], st_r.dfc_s[1],
                     evt.cell_ov & evt.lithium,
                     evt.cell_uv & evt.lithium};

      // status flags; a set in the same cycle as its clear wins
      if (evt.cal_lost)
         st_nxt.calibrated_flag = 1'b0;
      if (evt.cal_done)
         st_nxt.calibrated_flag = 1'b1;
      st_nxt.not_charging_flag = ~evt.charging;
      if (evt.charge_ok)
         st_nxt.charge_done_flag = 1'b0;
      if (evt.term_reached)
         st_nxt.charge_done_flag = 1'b1;
      if (evt.relative_charge_percent >= GSR_RECOVER_PCT)
         st_nxt.depleted_flag = 1'b0;
      if (evt.depleted)
         st_nxt.depleted_flag = 1'b1;

      // cycle count saturates; a save is only asked when it moved
      if (evt.cyc_load)
         st_nxt.cyc = evt.cyc_load_val;
      else if (evt.cyc_inc && st_r.cyc != GSR_CYC_MAX)
      begin
         st_nxt.cyc = st_r.cyc + 16'h0001;
         st_nxt.cyc_save = 1'b1;
      end

      // core events report into the error field
      if (evt.ovf_evt)
         st_nxt.err = GSR_ERR_OVF;
      if (evt.unk_evt)
         st_nxt.err = GSR_ERR_UNK;

      // read data for the present function code
      unique case (st_r.cmd)
         GSR_FC_STATUS: rd[15:0] = status_w;
         GSR_FC_CYCLE:  rd[15:0] = st_r.cyc;
         GSR_FC_DCAP:   rd[15:0] = evt.capacity_mode ?
                                   id.cap_10mwh : id.cap_mah;
         GSR_FC_DVOLT:  rd[15:0] = id.volt_mv;
         GSR_FC_SPEC:   rd[15:0] = {GSR_SCALE_ZERO, GSR_SCALE_ZERO,
                                    id.spec_major, id.spec_minor};
         GSR_FC_DATE:   rd[15:0] = {id.date_year, id.date_month,
                                    id.date_day};
         GSR_FC_SERIAL: rd[15:0] = id.serial;
         GSR_FC_MAKER:
         begin
            rd = id.maker_blk;
            rn = GSR_MAKER_BYTES;
         end
         GSR_FC_MODEL:
         begin
            rd[63:0] = id.model_blk;
            rn = GSR_MODEL_BYTES;
         end
         GSR_FC_CHEM:
         begin
            rd[47:0] = id.chem_blk;
            rn = GSR_SHORT_BYTES;
         end
         GSR_FC_MDATA:
         begin
            rd[47:0] = id.mdata_blk;
            rn = GSR_SHORT_BYTES;
         end
         GSR_FC_PACK:   rd[15:0] = {id.pack_cfg, st_r.prot};
         default:       rn = 4'h0;
      endcase

      // smbus slave; start and stop override any phase
      if (bus_start)
      begin
         st_nxt.ph = GSR_ADDR;
         st_nxt.bitcnt = 4'h0;
         st_nxt.sda_oe = 1'b0;
      end
      else if (bus_stop)
      begin
         if (st_r.ph == GSR_WDATA && st_r.wcnt != 5'h00)
         begin
            if (cls != GSR_ERR_OK)
               st_nxt.err = cls;
            else if (st_r.wcnt[3:0] != code_size(st_r.cmd) ||
                     st_r.wcnt[4])
               st_nxt.err = GSR_ERR_SIZE;
            else
               st_nxt.err = GSR_ERR_DENY;
         end
         st_nxt.ph = GSR_IDLE;
         st_nxt.sda_oe = 1'b0;
      end
      else
      begin
         unique case (st_r.ph)
            GSR_IDLE, GSR_IGNORE:
               st_nxt.sda_oe = 1'b0;
            GSR_ADDR, GSR_CMD, GSR_WDATA:
            begin
               if (scl_rise)
               begin
                  st_nxt.shreg = {st_r.shreg[6:0], st_r.sda_s[1]};
                  st_nxt.bitcnt = st_r.bitcnt + 4'h1;
               end
               else if (scl_fall && st_r.bitcnt == GSR_BITS_BYTE)
               begin
                  st_nxt.sda_oe = 1'b1;
                  if (st_r.ph == GSR_ADDR)
                  begin
                     st_nxt.rw = st_r.shreg[0];
                     st_nxt.ph = (st_r.shreg[7:1] == GSR_SLAVE_ADDR) ?
                                 GSR_ACK_A : GSR_IGNORE;
                     st_nxt.sda_oe = (st_r.shreg[7:1] == GSR_SLAVE_ADDR);
                  end
                  else if (st_r.ph == GSR_CMD)
                  begin
                     st_nxt.cmd = st_r.shreg;
                     st_nxt.wcnt = 5'h00;
                     st_nxt.ph = GSR_ACK_C;
                  end
                  else
                  begin
                     if (st_r.wcnt == 5'h00)
                        st_nxt.wlen = st_r.shreg;
                     if (!st_r.wcnt[4])
                        st_nxt.wcnt = st_r.wcnt + 5'h01;
                     st_nxt.ph = GSR_ACK_W;
                  end
               end
            end
            GSR_ACK_A, GSR_ACK_C, GSR_ACK_W:
            begin
               if (scl_fall)
               begin
                  st_nxt.bitcnt = 4'h0;
                  st_nxt.sda_oe = 1'b0;
                  if (st_r.ph == GSR_ACK_A && st_r.rw)
                  begin
                     // snapshot the word or block so all its bytes come from one instant
                     st_nxt.rdbuf = fill(rd, rn);
                     st_nxt.nbytes = rn;
                     st_nxt.idx = 4'h0;
                     st_nxt.ovf_rd = 1'b0;
                     st_nxt.sda_oe = ~st_nxt.rdbuf[7];
                     st_nxt.ph = GSR_TX;
                  end
                  else
                     st_nxt.ph = (st_r.ph == GSR_ACK_A) ? GSR_CMD : GSR_WDATA;
               end
            end
            GSR_TX:
            begin
               if (scl_rise)
                  st_nxt.bitcnt = st_r.bitcnt + 4'h1;
               else if (scl_fall)
               begin
                  if (st_r.bitcnt == GSR_BITS_BYTE)
                  begin
                     st_nxt.sda_oe = 1'b0;
                     st_nxt.ph = GSR_TX_ACK;
                  end
                  else
                     st_nxt.sda_oe = ~tx_byte[3'(4'h7 - st_r.bitcnt)];
               end
            end
            GSR_TX_ACK:
            begin
               if (scl_rise)
               begin
                  if (st_r.sda_s[1])
                  begin
                     // host nack ends the read and sets the outcome
                     st_nxt.ph = GSR_IGNORE;
                     if (evt.busy)
                        st_nxt.err = GSR_ERR_BUSY;
                     else if (st_r.ovf_rd && cls == GSR_ERR_OK)
                        st_nxt.err = GSR_ERR_OVF;
                     else
                        st_nxt.err = cls;
                  end
                  else
                  begin
                     if (st_r.idx != GSR_IDX_MAX)
                        st_nxt.idx = st_r.idx + 4'h1;
                     if (st_r.idx + 4'h1 >= st_r.nbytes)
                        st_nxt.ovf_rd = 1'b1;
                     st_nxt.ph = GSR_TX_LD;
                  end
               end
            end
            GSR_TX_LD:
            begin
               if (scl_fall)
               begin
                  st_nxt.bitcnt = 4'h0;
                  st_nxt.sda_oe = ~tx_byte[7];
                  st_nxt.ph = GSR_TX;
               end
            end
            default:
               st_nxt.ph = GSR_IDLE;
         endcase
      end
      st_nxt.sda_o = 1'b0;   // open drain: only ever pulls low
   end

   // single state register of the block
   always_ff @(posedge ref_clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         st_r <= '0;
         st_r.not_charging_flag <= 1'b1;
         st_r.scl_s <= 3'h7;
         st_r.sda_s <= 3'h7;
      end
      else
         st_r <= st_nxt;
   end

   assign sda_o             = st_r.sda_o;
   assign sda_oe            = st_r.sda_oe;
   assign wear_cycle_count  = st_r.cyc;
   assign cycle_save_stb    = st_r.cyc_save;
   assign gauge_status_word = status_w;
endmodule

// *** testbench/gsr_regs_asserts.sv ***
`timescale 1ns/1ns
// flags, error code and wear count
module gsr_regs_asserts
   import gsr_pkg::*;
(
   input wire logic              ref_clk,
   input wire logic              nrst,
   input wire logic              sda_o,
   input wire gsr_pkg::gsr_evt_t evt,
   input wire logic [15:0]       gauge_status_word,
   input wire logic [15:0]       wear_cycle_count,
   input wire logic              cycle_save_stb
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // flags answer their events on the next edge
   a_cal_set: assert property (
      evt.cal_done |=> gauge_status_word[7]) else $error("cal not set");
   a_cal_clr: assert property (
      evt.cal_lost && !evt.cal_done |=> !gauge_status_word[7])
      else $error("cal not cleared");
   a_chg_follow: assert property (
      gauge_status_word[6] == !$past(evt.charging))
      else $error("not charging flag wrong");
   a_done_set: assert property (
      evt.term_reached |=> gauge_status_word[5]) else $error("done flag");
   a_depl_set: assert property (
      evt.depleted |=> gauge_status_word[4]) else $error("depleted set");
   // the depleted flag holds below 20 percent and drops at or above it
   a_depl_clr: assert property (
      !evt.depleted && evt.relative_charge_percent >= 7'h14
      |=> !gauge_status_word[4]) else $error("depleted clear");
   a_depl_hold: assert property (
      gauge_status_word[4] && evt.relative_charge_percent < 7'h14
      |=> gauge_status_word[4]) else $error("depleted hold");
   a_err_ovf: assert property (
      evt.ovf_evt && !evt.unk_evt |=> gauge_status_word[2:0] == 3'h5)
      else $error("overflow code");
   a_err_unk: assert property (
      evt.unk_evt |=> gauge_status_word[2:0] == 3'h7)
      else $error("unknown code");
   a_fixed_zero: assert property (
      gauge_status_word[15:8] == 8'h00 && !gauge_status_word[3] && !sda_o)
      else $error("fixed bits");
   // count steps by one with a store request, and sticks at the top
   a_cnt_step: assert property (
      evt.cyc_inc && !evt.cyc_load && wear_cycle_count != 16'hffff
      |=> wear_cycle_count == $past(wear_cycle_count) + 16'h1
      && cycle_save_stb) else $error("count step");
   a_cnt_top: assert property (
      wear_cycle_count == 16'hffff && !evt.cyc_load
      |=> wear_cycle_count == 16'hffff && !cycle_save_stb)
      else $error("count wrapped");
   a_save_step: assert property (
      cycle_save_stb |-> wear_cycle_count == $past(wear_cycle_count) + 16'h1)
      else $error("save without step");
endmodule
bind gsr_status_info_regs gsr_regs_asserts u_chk (.ref_clk(ref_clk),
   .nrst(nrst), .sda_o(sda_o), .evt(evt),
   .gauge_status_word(gauge_status_word),
   .wear_cycle_count(wear_cycle_count), .cycle_save_stb(cycle_save_stb));

// *** testbench/gsr_host_model.sv ***
`timescale 1ns/1ns
// smbus host: owns the clock, only ever pulls data low
module gsr_host_model
(
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   logic [7:0] buf_q [13];
   // bus idles released with the clock high
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // long low phase covers the slave's sync delay
   task automatic bw(input logic b);
      #8 sda_pull = ~b;
      #32 scl = 1'b1;
      #24 scl = 1'b0;
   endtask
   task automatic br(output logic b);
      #8 sda_pull = 1'b0;
      #32 scl = 1'b1;
      b = sda;
      #24 scl = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] v, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--)
         bw(v[i]);
      br(b);
      ack = ~b;
   endtask
   // msb first; the last byte gets a nack
   task automatic rbyte(input logic last, output logic [7:0] v);
      for (int i = 7; i >= 0; i--)
         br(v[i]);
      bw(last);
   endtask
   // start or repeated start: data falls while the clock is high
   task automatic start;
      #8 sda_pull = 1'b0;
      #32 scl = 1'b1;
      #24 sda_pull = 1'b1;
      #24 scl = 1'b0;
   endtask
   task automatic stop;
      #8 sda_pull = 1'b1;
      #32 scl = 1'b1;
      #24 sda_pull = 1'b0;
      #24;
   endtask
   // read word/block after a repeated start, or write; ack is the address
   task automatic xfer(input logic [7:0] cmd, input logic rd, input int n,
                       output logic ack);
      logic a;
      start;
      wbyte({gsr_pkg::GSR_SLAVE_ADDR, 1'b0}, ack);
      wbyte(cmd, a);
      if (rd)
      begin
         start;
         wbyte({gsr_pkg::GSR_SLAVE_ADDR, 1'b1}, a);
         for (int i = 0; i < n; i++)
            rbyte(i == n - 1, buf_q[i]);
      end
      else
         for (int i = 0; i < n; i++)
            wbyte(buf_q[i], a);
      stop;
   endtask
endmodule

// *** testbench/gsr_status_info_regs_tb_top.sv ***
`timescale 1ns/1ns
`define CHK(a, b, m) chk((a) !== (b), m)
module gsr_status_info_regs_tb_top;
   import gsr_pkg::*;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        cfet = 1'b0;
   logic        dfet = 1'b0;
   gsr_evt_t    evt = '0;
   gsr_id_t     id = '0;
   wire logic   scl, pull, sda_o, sda_oe, save;
   wire logic   sda = ~(pull | sda_oe);
   wire logic [15:0] gsw, cnt;
   logic [15:0] exp_cnt = 16'h0;
   logic [15:0] ew;
   logic        ack;
   int          comparisons = 0, miscompares = 0, seed = 28, cyc = 0;
   logic [7:0]  wc [7] = '{8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h2f};
   int          bn [4] = '{12, 8, 6, 6};
   logic [7:0]  ec [4] = '{8'h18, 8'h18, 8'h30, 8'h05};
   int          en [4] = '{2, 3, 2, 2};
   logic [2:0]  ee [4] = '{3'h4, 3'h6, 3'h2, 3'h3};

   always #4 ref_clk = ~ref_clk;

   gsr_status_info_regs uut (.ref_clk(ref_clk), .nrst(nrst), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .charge_fet_control_pin(cfet), .discharge_fet_control_pin(dfet),
      .evt(evt), .id(id), .gauge_status_word(gsw),
      .wear_cycle_count(cnt), .cycle_save_stb(save));
   gsr_host_model host (.scl(scl), .sda_pull(pull), .sda(sda));

   task automatic chk(input logic bad, input string m);
      comparisons++;
      if (bad)
      begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   task automatic close_out;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // one-cycle event pulse, then one edge for the flag to land
   task automatic pulse(input gsr_evt_t m);
      @(negedge ref_clk) evt = evt | m;
      @(negedge ref_clk) evt = evt & ~m;
      @(negedge ref_clk);
   endtask

   // error code settles within eight cycles of the stop
   task automatic xf(input logic [7:0] c, input logic r, input int n);
      host.xfer(c, r, n, ack);
      repeat (8) @(negedge ref_clk);
   endtask

   function automatic logic [15:0] exp_word(input logic [7:0] c);
      case (c)
         8'h17: return exp_cnt;
         8'h18: return evt.capacity_mode ? id.cap_10mwh : id.cap_mah;
         8'h19: return id.volt_mv;
         8'h1a: return {8'h00, id.spec_major, id.spec_minor};
         8'h1b: return {id.date_year, id.date_month, id.date_day};
         8'h1c: return id.serial;
         default: return {id.pack_cfg, 4'h0, cfet, dfet,
                          evt.cell_ov & evt.lithium, evt.cell_uv & evt.lithium};
      endcase
   endfunction

   function automatic logic [7:0] exp_byte(input int b, input int i);
      logic [95:0] d;
      d = b == 0 ? id.maker_blk : b == 1 ? 96'(id.model_blk) :
          b == 2 ? 96'(id.chem_blk) : 96'(id.mdata_blk);
      return 8'(d >> (8 * i));
   endfunction

   // a hang is cut short here and counts as a mismatch
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         miscompares++;
         close_out;
      end
   end

   initial
   begin
      repeat (20) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (6) @(negedge ref_clk);
      `CHK(gsw, 16'h0040, "status after reset");
      pulse('{cal_done: 1'b1, default: '0});
      `CHK(gsw[7], 1'b1, "calibrated set");
      pulse('{cal_lost: 1'b1, default: '0});
      `CHK(gsw[7], 1'b0, "calibrated clear");
      evt.charging = 1'b1;
      repeat (2) @(negedge ref_clk);
      `CHK(gsw[6], 1'b0, "charging seen");
      evt.charging = 1'b0;
      pulse('{term_reached: 1'b1, default: '0});
      `CHK(gsw[5], 1'b1, "charge done set");
      pulse('{charge_ok: 1'b1, default: '0});
      `CHK(gsw[5], 1'b0, "charge done clear");
      evt.relative_charge_percent = 7'h13;
      pulse('{depleted: 1'b1, default: '0});
      `CHK(gsw[4], 1'b1, "depleted held at 19");
      evt.relative_charge_percent = 7'h14;
      repeat (2) @(negedge ref_clk);
      `CHK(gsw[4], 1'b0, "depleted clear at 20");
      $display("end of flag test");
      // loads near the top so the count reaches its ceiling
      for (int i = 0; i < 60; i++)
      begin
         evt.cyc_load = (i == 0) || ($random(seed) % 8 == 0);
         evt.cyc_load_val = {12'hfff, 4'($random(seed))};
         evt.cyc_inc = 1'($random(seed));
         exp_cnt = evt.cyc_load ? evt.cyc_load_val :
            exp_cnt + 16'(evt.cyc_inc && exp_cnt != 16'hffff);
         @(negedge ref_clk);
         evt.cyc_load = 1'b0;
         evt.cyc_inc = 1'b0;
         @(negedge ref_clk);
         `CHK(cnt, exp_cnt, "cycle count");
      end
      $display("end of count test");
      for (int i = 0; i < 12; i++)
         id = {id[335:0], 32'($random(seed))};
      {cfet, dfet, evt.lithium, evt.cell_ov, evt.cell_uv} = 5'($random(seed));
      for (int k = 0; k < 14; k++)
      begin
         evt.capacity_mode = k[0];
         xf(wc[k / 2], 1'b1, 2);
         ew = exp_word(wc[k / 2]);
         `CHK(host.buf_q[0], ew[7:0], "lo");
         `CHK(host.buf_q[1], ew[15:8], "hi");
         `CHK(gsw[2:0], GSR_ERR_OK, "ok code");
      end
      `CHK(ack, 1'b1, "address ack");
      for (int b = 0; b < 4; b++)
      begin
         xf(8'h20 + 8'(b), 1'b1, bn[b] + 1);
         for (int i = 0; i < bn[b]; i++)
            `CHK(host.buf_q[i], exp_byte(b, i), "block byte");
         `CHK(host.buf_q[bn[b]], 8'hff, "past block end");
         `CHK(gsw[2:0], GSR_ERR_OVF, "past end code");
      end
      $display("end of read test");
      evt.busy = 1'b1;
      xf(GSR_FC_DVOLT, 1'b1, 2);
      `CHK(gsw[2:0], GSR_ERR_BUSY, "busy code");
      evt.busy = 1'b0;
      xf(GSR_FC_DVOLT, 1'b1, 2);
      `CHK({host.buf_q[1], host.buf_q[0]}, id.volt_mv, "retry");
      for (int e = 0; e < 4; e++)
      begin
         xf(ec[e], e == 3, en[e]);
         `CHK(gsw[2:0], ee[e], "error code");
      end
      pulse('{ovf_evt: 1'b1, default: '0});
      `CHK(gsw[2:0], GSR_ERR_OVF, "overflow code");
      pulse('{unk_evt: 1'b1, default: '0});
      `CHK(gsw[2:0], GSR_ERR_UNK, "unknown code");
      $display("end of error test");
      close_out;
   end
endmodule
